// ==== hdl/pps_pkg.sv ====
package pps_pkg;

	localparam int ADDR_W = 20;
	localparam int NPIN = 7;
	localparam int NREG = 8;
	localparam int WS_W = 4;
	localparam int BASE_LO = 11;
	localparam int BASE_HI = 19;
	localparam int RGN_LO = 8;
	localparam int RGN_HI = 10;
	localparam int PIN_TWO = 2;
	localparam int PIN_THREE = 3;
	localparam int PIN_FIVE = 5;
	localparam int PIN_SIX = 6;
	localparam int BIT_A1 = 1;
	localparam int BIT_A2 = 2;
	localparam logic [NPIN-1:0] PIN_PRESENT = 7'h6F;
	localparam logic [NPIN-1:0] PIN_FC = 7'h0C;
	localparam logic [NPIN-1:0] PIN_EX = 7'h60;

	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_WAIT = 12'h004;
	localparam logic [11:0] REG_STAT = 12'h008;
	localparam int C_FC = 0;
	localparam int C_EX = 1;
	localparam int C_IO = 2;
	localparam int C_RXS = 3;
	localparam int C_SND = 4;
	localparam int S_DRAM = 7;
	localparam int S_BUSY = 8;
	localparam int S_CTS = 9;
	localparam int S_RXEN = 10;

	typedef enum logic {PPS_TX_IDLE, PPS_TX_FRAME} pps_tx_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic io;
		logic phase;
		logic cycle;
		logic hold;
		logic dram_hit;
	} pps_bus_t;

	typedef struct packed {
		logic [NPIN-1:0] o;
		logic [NPIN-1:0] oe_n;
	} pps_pins_t;

	typedef struct packed {
		logic [BASE_HI-BASE_LO:0] base;
		logic io;
		logic ex;
		logic fc;
		logic rxs;
		logic snd;
		logic [NREG*WS_W-1:0] waits;
		logic [NPIN-1:0] sel_act;
		logic [RGN_HI-RGN_LO:0] region;
		logic io_lat;
		logic a1;
		logic a2;
		logic dram_go;
		logic [WS_W-1:0] wait_cnt;
		pps_tx_t tx_st;
		logic tx_start;
		logic rx_en;
		logic [31:0] prdata;
		logic err;
		pps_pins_t pins;
	} pps_state_t;

	localparam pps_state_t ST_RST = '{
		base: '0, io: 1'b0, ex: 1'b1, fc: 1'b0, rxs: 1'b0, snd: 1'b0,
		waits: '0, sel_act: '0, region: '0, io_lat: 1'b0, a1: 1'b0,
		a2: 1'b0, dram_go: 1'b0, wait_cnt: '0, tx_st: PPS_TX_IDLE,
		tx_start: 1'b0, rx_en: 1'b1, prdata: '0, err: 1'b0,
		pins: '{o: '1, oe_n: '1}
	};

endpackage : pps_pkg

// ==== hdl/pps_sync.sv ====
`timescale 1ns/10ps
module pps_sync
	import pps_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic d,
	output logic q
);

	logic [1:0] ff_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ff_q <= 2'h3;
		end else begin
			ff_q <= {ff_q[0], d};
		end
	end

	assign q = ff_q[1];

endmodule : pps_sync

// ==== hdl/pps_pinmux.sv ====
`timescale 1ns/10ps
module pps_pinmux
	import pps_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pps_bus_t bus,
	output logic dram_go,
	output logic [WS_W-1:0] periph_wait,
	input wire logic tx_has_data,
	input wire logic tx_done,
	input wire logic rx_has_data,
	output logic tx_start,
	output logic rx_enable,
	input wire logic pin_two_i,
	output pps_pins_t pins
);

	// ----------------------------------------
	// State and input synchroniser
	// ----------------------------------------

	pps_state_t state_q;
	pps_state_t state_d;
	logic pin_two_s;
	logic blk_hit;
	logic [RGN_HI-RGN_LO:0] rgn;
	logic [NPIN-1:0] hit_vec;
	logic [NPIN-1:0] avail;
	logic cts_ok;
	logic enrx_ok;
	logic setup;
	logic wr;
	logic mapped;
	logic [31:0] rd_mux;

	pps_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(pin_two_i),
		.q(pin_two_s)
	);

	// ----------------------------------------
	// Region decode
	// ----------------------------------------

	assign rgn = bus.addr[RGN_HI:RGN_LO];
	assign blk_hit = (bus.addr[BASE_HI:BASE_LO] == state_q.base)
		&& (bus.io == state_q.io);

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_hit
			assign hit_vec[gi] = blk_hit
				&& (rgn == (RGN_HI-RGN_LO+1)'(gi));
		end
	endgenerate

	always_comb begin
		avail = PIN_PRESENT;
		if (state_q.fc) begin
			avail = avail & ~PIN_FC;
		end
		if (!state_q.ex) begin
			avail = avail & ~PIN_EX;
		end
	end

	// ----------------------------------------
	// Flow control inputs
	// ----------------------------------------

	// Shared input is active low
	assign cts_ok = !(state_q.fc && !state_q.rxs) || !pin_two_s;
	assign enrx_ok = !(state_q.fc && state_q.rxs) || !pin_two_s;

	// ----------------------------------------
	// Register bus
	// ----------------------------------------

	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite;
	assign mapped = (paddr == REG_CTRL) || (paddr == REG_WAIT)
		|| (paddr == REG_STAT);

	always_comb begin
		rd_mux = '0;
		unique case (paddr)
			REG_CTRL: begin
				rd_mux[BASE_HI:BASE_LO] = state_q.base;
				rd_mux[C_FC] = state_q.fc;
				rd_mux[C_EX] = state_q.ex;
				rd_mux[C_IO] = state_q.io;
				rd_mux[C_RXS] = state_q.rxs;
				rd_mux[C_SND] = state_q.snd;
			end
			REG_WAIT: begin
				rd_mux = state_q.waits;
			end
			REG_STAT: begin
				rd_mux[NPIN-1:0] = state_q.sel_act;
				rd_mux[S_DRAM] = state_q.dram_go;
				rd_mux[S_BUSY] = (state_q.tx_st == PPS_TX_FRAME);
				rd_mux[S_CTS] = !pin_two_s;
				rd_mux[S_RXEN] = state_q.rx_en;
			end
			default: begin
				rd_mux = '0;
			end
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------

	always_comb begin
		state_d = state_q;
		state_d.tx_start = 1'b0;

		if (setup) begin
			state_d.prdata = rd_mux;
			state_d.err = !mapped;
		end
		if (wr && paddr == REG_CTRL) begin
			state_d.base = pwdata[BASE_HI:BASE_LO];
			state_d.fc = pwdata[C_FC];
			state_d.ex = pwdata[C_EX];
			state_d.io = pwdata[C_IO];
			state_d.rxs = pwdata[C_RXS];
			state_d.snd = pwdata[C_SND];
		end
		if (wr && paddr == REG_WAIT) begin
			state_d.waits = pwdata;
		end

		// Selects latch at the address phase and hold for the cycle
		if (!bus.cycle) begin
			state_d.sel_act = '0;
			state_d.dram_go = 1'b0;
		end else if (bus.phase && !bus.hold) begin
			state_d.sel_act = hit_vec & avail;
			state_d.region = rgn;
			state_d.io_lat = bus.io;
			state_d.a1 = bus.addr[BIT_A1];
			state_d.a2 = bus.addr[BIT_A2];
			state_d.dram_go = bus.dram_hit && !blk_hit;
			state_d.wait_cnt = state_q.waits[{rgn, 2'h0} +: WS_W];
		end

		// Transmit gating, sampled once per frame
		unique case (state_q.tx_st)
			PPS_TX_IDLE: begin
				if (tx_has_data && cts_ok) begin
					state_d.tx_start = 1'b1;
					state_d.tx_st = PPS_TX_FRAME;
				end
			end
			PPS_TX_FRAME: begin
				if (tx_done) begin
					state_d.tx_st = PPS_TX_IDLE;
				end
			end
		endcase
		state_d.rx_en = enrx_ok;

		// Pin drive, selects active low
		state_d.pins.o = ~state_d.sel_act | {NPIN{bus.hold}} | ~PIN_PRESENT;
		state_d.pins.oe_n = {NPIN{bus.hold}} | ~PIN_PRESENT;
		if (state_q.fc) begin
			state_d.pins.o[PIN_TWO] = 1'b1;
			state_d.pins.oe_n[PIN_TWO] = 1'b1;
			state_d.pins.oe_n[PIN_THREE] = 1'b0;
			if (state_q.snd) begin
				state_d.pins.o[PIN_THREE] = !tx_has_data;
			end else begin
				state_d.pins.o[PIN_THREE] = rx_has_data;
			end
		end
		if (!state_q.ex) begin
			state_d.pins.o[PIN_FIVE] = state_d.a1;
			state_d.pins.o[PIN_SIX] = state_d.a2;
			state_d.pins.oe_n[PIN_FIVE] = 1'b0;
			state_d.pins.oe_n[PIN_SIX] = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_RST;
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------

	assign prdata = state_q.prdata;
	assign pready = 1'b1;
	assign pslverr = state_q.err;
	assign dram_go = state_q.dram_go;
	assign periph_wait = state_q.wait_cnt;
	assign tx_start = state_q.tx_start;
	assign rx_enable = state_q.rx_en;
	assign pins = state_q.pins;

	// ----------------------------------------
	// Checks
	// ----------------------------------------

	AST_REGION: assert property (@(posedge pclk) disable iff (!presetn)
		state_q.sel_act[1] |-> state_q.region == 3'h1)
		else $error("select one active outside its region");

	AST_SPACE: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q.sel_act != '0) |-> state_q.io_lat == state_q.io)
		else $error("select active in wrong address space");

	AST_DRAM: assert property (@(posedge pclk) disable iff (!presetn)
		(bus.cycle && bus.phase && !bus.hold && blk_hit && bus.dram_hit)
		|=> !dram_go)
		else $error("dram cycle run over a select region");

	AST_PHASE: assert property (@(posedge pclk) disable iff (!presetn)
		(bus.cycle && bus.phase && !bus.hold && hit_vec[0])
		|=> (state_q.sel_act[0] && !pins.o[0]))
		else $error("select zero did not follow the address phase");

	AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		bus.hold |=> (pins.oe_n[0] && pins.oe_n[1]))
		else $error("select driven during bus hold");

	AST_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
		(bus.cycle && bus.phase && !bus.hold && rgn == 3'h2)
		|=> periph_wait == $past(state_q.waits[11:8]))
		else $error("wait count not taken from the region setting");

	AST_FC_PIN: assert property (@(posedge pclk) disable iff (!presetn)
		$past(state_q.fc) |-> (pins.oe_n[PIN_TWO] && !state_q.sel_act[PIN_THREE]))
		else $error("select two or three active under flow control");

	AST_CTS: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q.tx_st == PPS_TX_IDLE && tx_has_data && !cts_ok)
		|=> !tx_start)
		else $error("frame started while clear-to-send deasserted");

	AST_FRAME: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q.tx_st == PPS_TX_FRAME && !tx_done)
		|=> (state_q.tx_st == PPS_TX_FRAME && !tx_start))
		else $error("frame disturbed before it ended");

	AST_RTS: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q.fc && state_q.snd && tx_has_data) |=> !pins.o[PIN_THREE])
		else $error("ready-to-send not asserted with pending data");

	AST_A1: assert property (@(posedge pclk) disable iff (!presetn)
		(!state_q.ex && bus.hold) |=> (!pins.oe_n[PIN_FIVE]
		&& pins.o[PIN_FIVE] == $past(state_q.a1)))
		else $error("latched bit one not kept in bus hold");

	AST_SIX: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q.ex && bus.hold) |=> (pins.o[PIN_SIX] && pins.oe_n[PIN_SIX]))
		else $error("select six not released high in hold");

	AST_HOLD_FLOAT: assert property (@(posedge pclk) disable iff (!presetn)
		(bus.hold && !state_q.fc)
		|=> (pins.oe_n[PIN_TWO] && pins.oe_n[PIN_THREE]))
		else $error("select two or three driven during bus hold");

	AST_HOLD_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
		bus.hold
		|=> (pins.o[0] && pins.o[1]))
		else $error("floated select not left high in bus hold");

	AST_FIVE_FLOAT: assert property (@(posedge pclk) disable iff (!presetn)
		(bus.hold && state_q.ex)
		|=> (pins.oe_n[PIN_FIVE] && pins.o[PIN_FIVE]))
		else $error("select five driven during bus hold");

	AST_SEL_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
		!bus.cycle
		|=> ((state_q.sel_act == '0) && pins.o[0] && pins.o[1]))
		else $error("select left active outside a bus cycle");

	AST_GATE_FC: assert property (@(posedge pclk) disable iff (!presetn)
		(bus.cycle && bus.phase && !bus.hold && state_q.fc)
		|=> (!state_q.sel_act[PIN_TWO] && !state_q.sel_act[PIN_THREE]))
		else $error("select two or three decoded under flow control");

	AST_GATE_EX: assert property (@(posedge pclk) disable iff (!presetn)
		(bus.cycle && bus.phase && !bus.hold && !state_q.ex)
		|=> (!state_q.sel_act[PIN_FIVE] && !state_q.sel_act[PIN_SIX]))
		else $error("select five or six decoded in latched address mode");

	AST_NO_PIN: assert property (@(posedge pclk) disable iff (!presetn)
		(bus.cycle && bus.phase && !bus.hold)
		|=> ((state_q.sel_act & ~PIN_PRESENT) == '0))
		else $error("select decoded for a region without a pin");

	AST_FIVE_SEL: assert property (@(posedge pclk) disable iff (!presetn)
		(bus.cycle && bus.phase && !bus.hold && state_q.ex && hit_vec[PIN_FIVE])
		|=> !pins.o[PIN_FIVE])
		else $error("select five not asserted for the sixth region");

	AST_SIX_SEL: assert property (@(posedge pclk) disable iff (!presetn)
		(bus.cycle && bus.phase && !bus.hold && state_q.ex && hit_vec[PIN_SIX])
		|=> !pins.o[PIN_SIX])
		else $error("select six not asserted for the seventh region");

	AST_LAT_A1: assert property (@(posedge pclk) disable iff (!presetn)
		(bus.cycle && bus.phase && !bus.hold && !state_q.ex)
		|=> (!pins.oe_n[PIN_FIVE] && pins.o[PIN_FIVE] == $past(bus.addr[BIT_A1])))
		else $error("latched bit one not shown on pin five");

	AST_LAT_A2: assert property (@(posedge pclk) disable iff (!presetn)
		(!state_q.ex && bus.hold)
		|=> (!pins.oe_n[PIN_SIX] && pins.o[PIN_SIX] == $past(state_q.a2)))
		else $error("latched bit two not kept in bus hold");

	AST_RTR: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q.fc && !state_q.snd && !rx_has_data)
		|=> (!pins.o[PIN_THREE] && !pins.oe_n[PIN_THREE]))
		else $error("ready-to-receive not asserted with empty receiver");

	AST_RX_EN: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q.fc && state_q.rxs && pin_two_s)
		|=> !rx_enable)
		else $error("receiver enabled while request pin deasserted");

	AST_CTS_GO: assert property (@(posedge pclk) disable iff (!presetn)
		(state_q.tx_st == PPS_TX_IDLE && tx_has_data && state_q.fc && !state_q.rxs && !pin_two_s)
		|=> tx_start)
		else $error("frame not started with clear-to-send asserted");

	AST_START_ONE: assert property (@(posedge pclk) disable iff (!presetn)
		tx_start
		|=> !tx_start)
		else $error("frame start pulse longer than one cycle");

endmodule : pps_pinmux

// ==== tb/pps_periph.sv ====
`timescale 1ns/10ps
module pps_periph
	import pps_pkg::*;
(
	input wire logic pclk,
	input wire pps_pins_t pins,
	input wire logic cts_req,
	output logic pin_two_i,
	output logic [NPIN-1:0] lev,
	output logic sel_fall
);
	logic [NPIN-1:0] lev_q = '1;
	// ----
	// Pull-ups and shared input pin
	// ----
	// Floated pins read high through the pull-up
	assign lev = pins.o | pins.oe_n;
	// Peripheral asserts the shared input low only while the pin is not driven
	assign pin_two_i = pins.oe_n[PIN_TWO] ? ~cts_req : pins.o[PIN_TWO];
	always @(posedge pclk) lev_q <= lev;
	assign sel_fall = |(lev_q & ~lev & ~pins.oe_n);
endmodule : pps_periph

// ==== tb/pps_pinmux_bench.sv ====
`timescale 1ns/10ps
module pps_pinmux_bench
	import pps_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rnd = 32'h992B;
	logic pready, pslverr, dram_go, tx_start, rx_enable, pin_two_i, sel_fall;
	logic tx_has_data = 1'b0, tx_done = 1'b0, rx_has_data = 1'b1, cts_req = 1'b0;
	logic [WS_W-1:0] periph_wait;
	logic [NPIN-1:0] lev;
	pps_bus_t bus = '0;
	pps_pins_t pins;
	logic [32:0] exp_q[$];
	int fail_count = 0, check_count = 0;
	localparam logic [19:0] BLK = 20'hAD800;
	localparam logic [31:0] WV = 32'h9A3C_F5E2;
	always #2 pclk = ~pclk;
	pps_pinmux u_pps_pinmux(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .bus, .dram_go, .periph_wait, .tx_has_data, .tx_done,
		.rx_has_data, .tx_start, .rx_enable, .pin_two_i, .pins);
	pps_periph u_pps_periph(.pclk, .pins, .cts_req, .pin_two_i, .lev, .sel_fall);
	// ----
	// Tasks
	// ----
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic conclude;
		if (exp_q.size() != 0) fail_count++;
		if (fail_count == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : conclude
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, '0);
	endtask : rd
	task automatic cyc(input logic [19:0] a, input logic io);
		@(posedge pclk);
		bus <= '{a, io, 1'b1, 1'b1, 1'b0, 1'b1};
		@(posedge pclk);
		bus.phase <= 1'b0;
		@(posedge pclk);
		@(negedge pclk);
	endtask : cyc
	task automatic cyc_end;
		@(posedge pclk);
		bus.cycle <= 1'b0;
		bus.hold <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask : cyc_end
	task automatic hold_on;
		@(posedge pclk);
		bus.hold <= 1'b1;
		repeat (2) @(posedge pclk);
		@(negedge pclk);
	endtask : hold_on
	task automatic wait_start(input logic e);
		logic seen;
		seen = 1'b0;
		repeat (8) @(negedge pclk) seen |= (tx_start === 1'b1);
		chk(seen, e);
		@(posedge pclk);
	endtask : wait_start
	task automatic done_pulse;
		tx_done <= 1'b1;
		@(posedge pclk);
		tx_done <= 1'b0;
	endtask : done_pulse
	// ----
	// Result watcher and main sequence
	// ----
	always @(negedge pclk) begin
		if ((psel && penable && pready && !pwrite) || sel_fall) begin
			if (exp_q.size() == 0) chk(1'b1, 1'b0);
			else chk(sel_fall ? {26'h0, lev} : {pslverr, prdata}, exp_q.pop_front());
		end
	end
	initial begin
		repeat (5000) @(posedge pclk);
		fail_count++;
		conclude();
	end
	initial begin
		repeat (16) @(posedge pclk);
		chk({pins.o, pins.oe_n}, 14'h3FFF);
		presetn <= 1'b1;
		rd(REG_CTRL, 33'h2);
		rd(REG_WAIT, '0);
		rd(12'h00C, 33'h1_0000_0000);
		rd(REG_STAT, 33'h400);
		apb(1'b1, REG_WAIT, WV);
		for (int sp = 0; sp < 2; sp++) begin
			apb(1'b1, REG_CTRL, {12'h0, BLK[19:11], 8'h0, sp[0], 2'b10});
			rd(REG_CTRL, {13'h0, BLK[19:11], 8'h0, sp[0], 2'b10});
			for (int n = 0; n < 8; n++) begin
				rnd = lfsr(rnd);
				if (PIN_PRESENT[n]) exp_q.push_back({26'h0, 7'h7F & ~(7'h01 << n)});
				cyc(BLK | {9'h0, n[2:0], rnd[7:0]}, sp[0]);
				if (PIN_PRESENT[n]) begin
					chk(dram_go, 1'b0);
					chk(periph_wait, WV[4*n +: 4]);
				end
				cyc_end();
			end
			cyc(BLK, ~sp[0]);
			chk(dram_go, 1'b1);
			cyc_end();
		end
		exp_q.push_back({26'h0, 7'h3F});
		cyc(BLK | 20'h00600, 1'b1);
		hold_on();
		chk({pins.oe_n[6], lev[6], pins.oe_n[0]}, 3'b111);
		cyc_end();
		cyc(20'h00006, 1'b1);
		cyc_end();
		apb(1'b1, REG_CTRL, {12'h0, BLK[19:11], 11'h4});
		rnd = lfsr(rnd);
		if (rnd[2:1] != 2'b11) exp_q.push_back({26'h0, rnd[2:1], 5'h1F});
		cyc({BLK[19:11], 3'd5, rnd[7:0]}, 1'b1);
		hold_on();
		chk({pins.oe_n[6:5], lev[6:5]}, {2'b00, rnd[2:1]});
		cyc_end();
		apb(1'b1, REG_CTRL, 32'h13);
		exp_q.push_back({26'h0, 7'h77});
		tx_has_data <= 1'b1;
		wait_start(1'b0);
		chk(pins.oe_n[3:2], 2'b01);
		cyc(20'h00200, 1'b0);
		chk(lev[3:2], 2'b01);
		cyc_end();
		cts_req <= 1'b1;
		wait_start(1'b1);
		rd(REG_STAT, 33'h700);
		cts_req <= 1'b0;
		wait_start(1'b0);
		done_pulse();
		wait_start(1'b0);
		cts_req <= 1'b1;
		wait_start(1'b1);
		tx_has_data <= 1'b0;
		done_pulse();
		apb(1'b1, REG_CTRL, 32'h3);
		exp_q.push_back({26'h0, 7'h77});
		rx_has_data <= 1'b0;
		apb(1'b1, REG_CTRL, 32'hB);
		for (int v = 0; v < 2; v++) begin
			cts_req <= v[0];
			repeat (6) @(posedge pclk);
			@(negedge pclk);
			chk(rx_enable, v[0]);
			@(posedge pclk);
		end
		conclude();
	end
endmodule : pps_pinmux_bench
